// >>> pkg/dau_pkg.sv
// Package for the debug access unit: register map, fields, states and constants.
`default_nettype none
package dau_pkg;
    // Register byte offsets on the plain register port.
    localparam logic [7:0] DAU_OFF_CTRL = 8'h00;
    localparam logic [7:0] DAU_OFF_STAT = 8'h04;
    localparam logic [7:0] DAU_OFF_ADDR = 8'h08;
    localparam logic [7:0] DAU_OFF_LEN = 8'h0C;
    localparam logic [7:0] DAU_OFF_DATA = 8'h10;
    localparam logic [7:0] DAU_OFF_IMASK = 8'h14;
    localparam logic [7:0] DAU_OFF_ISTAT = 8'h18;
    // Control register command bits, all write-one-to-act.
    localparam int DAU_UNIT_ENABLE_CMD = 0;
    localparam int DAU_UNIT_DISABLE_CMD = 1;
    localparam int DAU_CRC_START_CMD = 2;
    localparam int DAU_CR_UPR = 3;
    // Status register fields.
    localparam int DAU_DONE_FLAG = 0;
    localparam int DAU_BUS_ERROR_FLAG = 1;
    localparam int DAU_FUNCTION_FAIL_FLAG = 2;
    localparam int DAU_SR_EN = 3;
    localparam int DAU_STATUS_STATE_FIELD_LSB = 8;
    // Interrupt status bits: done, bus error, failure.
    localparam int DAU_IRQ_W = 3;
    // User page size in words and its offset width.
    localparam int DAU_PAGE_AW = 7;
    // Protected CRC forced values: whole flash array, all-ones seed.
    localparam logic [31:0] DAU_FLASH_BASE = 32'h0000_0000;
    localparam logic [31:0] DAU_FLASH_SIZE = 32'h0008_0000;
    localparam logic [31:0] DAU_CRC_SEED = 32'hFFFF_FFFF;
    localparam logic [31:0] DAU_CRC_POLY = 32'hEDB8_8320;
    localparam logic [31:0] DAU_WORD_BYTES = 32'h0000_0004;
    // Unit states; the code is what the status state field shows.
    typedef enum logic [1:0] {
        DAU_ST_IDLE = 2'b00,
        DAU_ST_UPR = 2'b01,
        DAU_ST_CRC = 2'b10
    } dau_state_t;
endpackage
`default_nettype wire

// >>> src/dau_top.sv
// Debug access unit: user page reader and memory CRC32 engine.
//
// The implementer's own choices: the register addresses and the plain strobed port.
`default_nettype none
module dau_top
    import dau_pkg::*;
(
    input wire logic clk, // System clock, 100 MHz.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic [7:0] reg_addr, // Register byte address.
    input wire logic [31:0] reg_wdata, // Register write data.
    input wire logic reg_wr, // Register write strobe.
    input wire logic reg_rd, // Register read strobe.
    output logic [31:0] reg_rdata, // Read data, valid the cycle after reg_rd.
    output logic irq, // Level interrupt, unmasked status pending.
    input wire logic protected_mode, // Device protected state.
    output logic mem_req, // Memory read request.
    output logic [31:0] mem_addr, // Memory word byte address.
    output logic mem_upage, // Request targets the user page.
    input wire logic mem_ack, // Memory answer valid.
    input wire logic [31:0] mem_rdata, // Memory read word.
    input wire logic mem_err // Bus error on this answer.
);

    ////////////////////////////////////////////////////////////////////////////
    // State record.
    // Everything the unit remembers lives in this one record.
    typedef struct packed {
        dau_state_t st; // Current operation.
        logic en; // Unit enabled.
        logic done; // Done flag.
        logic berr; // Bus error flag.
        logic fail; // Functional failure flag.
        logic [31:0] addr; // Address register.
        logic [31:0] len; // Remaining length in bytes.
        logic [31:0] data; // Data / CRC register.
        logic [DAU_IRQ_W-1:0] imask; // Interrupt mask.
        logic [DAU_IRQ_W-1:0] istat; // Sticky interrupt status.
        logic req; // Outstanding memory request.
        logic [31:0] maddr; // Registered memory address.
        logic upage; // Registered page select.
        logic [31:0] rdata; // Registered read data.
        logic irq; // Registered interrupt.
    } dau_regs_t;

    dau_regs_t r_q; // Registered state.
    dau_regs_t r_d; // Next state.

    ////////////////////////////////////////////////////////////////////////////
    // CRC fold of one 32-bit word, least significant bit first.
    // The loop unrolls into a 32-deep xor tree, which is the long path of the block.
    // Folding a whole word per answer keeps the engine at one memory word per cycle.
    function automatic logic [31:0] dau_crc_word(input logic [31:0] crc, input logic [31:0] w);
        logic [31:0] c;
        c = crc;
        for (int i = 0; i < 32; i++) begin
            if (c[0] ^ w[i]) begin
                c = (c >> 1) ^ DAU_CRC_POLY;
            end else begin
                c = c >> 1;
            end
        end
        return c;
    endfunction

    // Helper nets of the next-state process, all driven inside it.
    logic [DAU_IRQ_W-1:0] ev; // Events this cycle: done, bus error, fail.
    logic [DAU_PAGE_AW-1:0] page_word; // Word offset within the page.
    logic wr_ctrl; // Control write this cycle.

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic: register port, command decode and sequencing.
    always_comb begin
        r_d = r_q;
        ev = '0;
        wr_ctrl = reg_wr && (reg_addr == DAU_OFF_CTRL);
        page_word = r_q.addr[DAU_PAGE_AW+1:2]; // Higher bits dropped silently.
        // Read data is zero except in the cycle after a read strobe.
        r_d.rdata = 32'h0000_0000;
        // Read decode; unmapped addresses return zero.
        if (reg_rd) begin
            unique case (reg_addr)
                DAU_OFF_STAT: begin
                    r_d.rdata = {22'h0, r_q.st, 4'h0, r_q.en, r_q.fail, r_q.berr, r_q.done};
                end
                DAU_OFF_ADDR: r_d.rdata = r_q.addr;
                DAU_OFF_LEN: r_d.rdata = r_q.len;
                DAU_OFF_DATA: r_d.rdata = r_q.data;
                DAU_OFF_IMASK: r_d.rdata = {29'h0, r_q.imask};
                DAU_OFF_ISTAT: r_d.rdata = {29'h0, r_q.istat};
                default: r_d.rdata = 32'h0000_0000;
            endcase
        end
        // Data registers are writable only while idle, so a run is not corrupted.
        if (reg_wr && r_q.st == DAU_ST_IDLE) begin
            if (reg_addr == DAU_OFF_ADDR) r_d.addr = reg_wdata;
            if (reg_addr == DAU_OFF_LEN) r_d.len = reg_wdata;
            if (reg_addr == DAU_OFF_DATA) r_d.data = reg_wdata;
        end
        if (reg_wr && reg_addr == DAU_OFF_IMASK) r_d.imask = reg_wdata[DAU_IRQ_W-1:0];
        // The mask may change at any time; masking never loses a status bit.
        // Memory sequencing.
        // Only one word is ever outstanding; the request holds until answered.
        // Start commands are ignored unless the unit is enabled and idle.
        unique case (r_q.st)
            DAU_ST_IDLE: begin
                if (wr_ctrl && r_q.en && reg_wdata[DAU_CR_UPR]) begin
                    // Protection is not checked for the page read.
                    // Flags of an earlier run are cleared, so done means this read.
                    r_d.st = DAU_ST_UPR;
                    r_d.done = 1'b0;
                    r_d.berr = 1'b0;
                    r_d.fail = 1'b0;
                    r_d.req = 1'b1;
                    r_d.upage = 1'b1;
                    r_d.maddr = {23'h0, page_word, 2'b00};
                end else if (wr_ctrl && r_q.en && reg_wdata[DAU_CRC_START_CMD]) begin
                    r_d.st = DAU_ST_CRC;
                    r_d.done = 1'b0;
                    r_d.berr = 1'b0;
                    r_d.fail = 1'b0;
                    r_d.upage = 1'b0;
                    // The forced range is never empty, so a protected run always requests.
                    if (protected_mode) begin
                        r_d.addr = DAU_FLASH_BASE;
                        r_d.len = DAU_FLASH_SIZE;
                        r_d.data = DAU_CRC_SEED;
                    end
                    // Misaligned range is a functional failure, not a hang.
                    // The range is checked before any word is requested.
                    if (!protected_mode && (r_q.addr[1:0] != 2'b00 || r_q.len[1:0] != 2'b00)) begin
                        r_d.st = DAU_ST_IDLE;
                        r_d.done = 1'b1;
                        r_d.fail = 1'b1;
                        ev = 3'h5;
                    end else if (!protected_mode && r_q.len == 32'h0000_0000) begin
                        r_d.st = DAU_ST_IDLE; // Empty range finishes at once.
                        r_d.done = 1'b1;
                        ev = 3'h1;
                    end else begin
                        r_d.req = 1'b1;
                        r_d.maddr = protected_mode ? DAU_FLASH_BASE : r_q.addr;
                    end
                end
            end
            DAU_ST_UPR: begin
                if (mem_ack) begin
                    // An error answer still ends the read; the word is then not trusted.
                    r_d.data = mem_rdata; // Word lands with done.
                    r_d.addr = r_q.addr + DAU_WORD_BYTES;
                    r_d.req = 1'b0;
                    r_d.st = DAU_ST_IDLE;
                    r_d.done = 1'b1;
                    r_d.berr = mem_err;
                    ev = {1'b0, mem_err, 1'b1};
                end
            end
            DAU_ST_CRC: begin
                if (mem_ack) begin
                    r_d.data = dau_crc_word(r_q.data, mem_rdata);
                    r_d.addr = r_q.addr + DAU_WORD_BYTES;
                    r_d.len = r_q.len - DAU_WORD_BYTES;
                    // The next address goes out at once so the request can stay high.
                    r_d.maddr = r_q.addr + DAU_WORD_BYTES;
                    // A bus error ends the run early; the partial CRC stays in data.
                    if (mem_err || r_q.len == DAU_WORD_BYTES) begin
                        r_d.req = 1'b0;
                        r_d.st = DAU_ST_IDLE;
                        r_d.done = 1'b1;
                        r_d.berr = mem_err;
                        ev = {1'b0, mem_err, 1'b1};
                    end
                end
            end
            default: r_d.st = DAU_ST_IDLE;
        endcase
        // Enable command.
        if (wr_ctrl && reg_wdata[DAU_UNIT_ENABLE_CMD]) r_d.en = 1'b1;
        // Disable wins over everything: abort, drop the request and return state, enable, flags and data registers to reset values.
        // The address is cleared too, so the host must reload it after enable.
        if (wr_ctrl && reg_wdata[DAU_UNIT_DISABLE_CMD]) begin
            r_d.st = DAU_ST_IDLE;
            r_d.en = 1'b0;
            r_d.req = 1'b0;
            r_d.done = 1'b0;
            r_d.berr = 1'b0;
            r_d.fail = 1'b0;
            r_d.addr = 32'h0000_0000;
            r_d.len = 32'h0000_0000;
            r_d.data = 32'h0000_0000;
            ev = '0;
        end
        // Sticky interrupt status: write one clears, a new event wins.
        if (reg_wr && reg_addr == DAU_OFF_ISTAT) begin
            r_d.istat = r_q.istat & ~reg_wdata[DAU_IRQ_W-1:0];
        end
        r_d.istat = r_d.istat | ev;
        // The interrupt is registered from the next status and mask, so it changes in the same cycle as the status.
        r_d.irq = |(r_d.istat & r_d.imask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register with synchronous reset.
    // An all-zero record is idle and disabled, so reset needs no special values.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // All outputs come straight from flip-flops.
    // No output is decoded combinationally, which keeps timing at the pins clean.
    assign reg_rdata = r_q.rdata;
    assign irq = r_q.irq;
    assign mem_req = r_q.req;
    assign mem_addr = r_q.maddr;
    assign mem_upage = r_q.upage;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.
    // Each property names its clock and reset so that it reads on its own.
    // Step antecedents leave out disable writes, since disable overrides every step.
    AST_UPR_STATE: assert property (@(posedge clk) disable iff (!rst_n)
        (r_q.st == DAU_ST_IDLE && wr_ctrl && r_q.en && reg_wdata[DAU_CR_UPR]
         && !reg_wdata[DAU_UNIT_DISABLE_CMD]) |=> r_q.st == DAU_ST_UPR && mem_upage)
        else $error("page read did not enter its state");
    AST_UPR_DATA: assert property (@(posedge clk) disable iff (!rst_n)
        (r_q.st == DAU_ST_UPR && mem_ack && !wr_ctrl) |=> r_q.done && r_q.data == $past(mem_rdata))
        else $error("page word not in data at done");
    AST_UPR_INC: assert property (@(posedge clk) disable iff (!rst_n)
        (r_q.st == DAU_ST_UPR && mem_ack && !wr_ctrl) |=> r_q.addr == $past(r_q.addr) + 32'h4)
        else $error("address not advanced after page read");
    AST_UPR_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
        (r_q.st == DAU_ST_UPR) |-> mem_addr[31:DAU_PAGE_AW+2] == '0)
        else $error("page address escaped page");
    AST_PROT_FORCE: assert property (@(posedge clk) disable iff (!rst_n)
        (r_q.st == DAU_ST_IDLE && wr_ctrl && r_q.en && reg_wdata[DAU_CRC_START_CMD]
         && !reg_wdata[DAU_CR_UPR] && !reg_wdata[DAU_UNIT_DISABLE_CMD] && protected_mode)
        |=> r_q.addr == DAU_FLASH_BASE && r_q.len == DAU_FLASH_SIZE && r_q.data == DAU_CRC_SEED)
        else $error("protected crc values not forced");
    AST_CRC_DONE: assert property (@(posedge clk) disable iff (!rst_n)
        (r_q.st == DAU_ST_CRC && mem_ack && r_q.len == 32'h4 && !wr_ctrl)
        |=> r_q.done && r_q.st == DAU_ST_IDLE ##1 r_q.istat[0])
        else $error("done not set at crc end");
    AST_CRC_LEN: assert property (@(posedge clk) disable iff (!rst_n)
        (r_q.st == DAU_ST_CRC && mem_ack && !wr_ctrl) |=> r_q.len == $past(r_q.len) - 32'h4)
        else $error("length not reduced by four");
    AST_DISABLE: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_ctrl && reg_wdata[DAU_UNIT_DISABLE_CMD]) |=> r_q.st == DAU_ST_IDLE && !r_q.en && !mem_req)
        else $error("disable did not reset unit");
    // A page read starts even while the device is protected.
    AST_UPR_PROT: assert property (@(posedge clk) disable iff (!rst_n)
        (r_q.st == DAU_ST_IDLE && wr_ctrl && r_q.en && reg_wdata[DAU_CR_UPR]
         && !reg_wdata[DAU_UNIT_DISABLE_CMD] && protected_mode) |=> r_q.st == DAU_ST_UPR)
        else $error("page read refused while protected");
    // The page request carries only the in-page word offset.
    AST_UPR_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
        (r_q.st == DAU_ST_IDLE && wr_ctrl && r_q.en && reg_wdata[DAU_CR_UPR]
         && !reg_wdata[DAU_UNIT_DISABLE_CMD])
        |=> mem_req && mem_addr == {23'h0, $past(r_q.addr[DAU_PAGE_AW+1:2]), 2'b00})
        else $error("page request address wrong");
    // The state field holds the page read code until the word is answered.
    AST_UPR_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        (r_q.st == DAU_ST_UPR && !mem_ack && !wr_ctrl) |=> r_q.st == DAU_ST_UPR)
        else $error("page read state left early");
    // A status read shows the state that stood when it was taken.
    AST_STAT_STATE: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr == DAU_OFF_STAT) |=> reg_rdata[9:8] == $past(r_q.st))
        else $error("status state field wrong");
    // A seed written while idle lands in the data register unchanged.
    AST_SEED_WR: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == DAU_OFF_DATA && r_q.st == DAU_ST_IDLE)
        |=> r_q.data == $past(reg_wdata))
        else $error("seed not taken into data");
    // The data register reads back as it stands, without inversion.
    AST_DATA_RD: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr == DAU_OFF_DATA) |=> reg_rdata == $past(r_q.data))
        else $error("data register read back wrong");
    // A protected start always runs, since the forced range is never empty.
    AST_CRC_START: assert property (@(posedge clk) disable iff (!rst_n)
        (r_q.st == DAU_ST_IDLE && wr_ctrl && r_q.en && reg_wdata[DAU_CRC_START_CMD]
         && !reg_wdata[DAU_CR_UPR] && !reg_wdata[DAU_UNIT_DISABLE_CMD] && protected_mode)
        |=> r_q.st == DAU_ST_CRC && mem_req && !mem_upage)
        else $error("crc did not start");
    // Every answered CRC word moves the request on by one word.
    AST_CRC_STEP: assert property (@(posedge clk) disable iff (!rst_n)
        (r_q.st == DAU_ST_CRC && mem_ack && !wr_ctrl) |=> mem_addr == $past(r_q.addr) + 32'h4)
        else $error("crc address not advanced");
    // Done stays low for as long as the run waits on memory.
    AST_CRC_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
        (r_q.st == DAU_ST_CRC && !mem_ack && !wr_ctrl) |=> r_q.st == DAU_ST_CRC && !r_q.done)
        else $error("crc ended without an answer");
    // A bus error ends the run with done and the error flag together.
    AST_BERR_END: assert property (@(posedge clk) disable iff (!rst_n)
        (r_q.st == DAU_ST_CRC && mem_ack && mem_err && !wr_ctrl)
        |=> r_q.done && r_q.berr && r_q.st == DAU_ST_IDLE)
        else $error("bus error did not end the run");
    // A misaligned range is reported as a failure straight away.
    AST_MISALIGN: assert property (@(posedge clk) disable iff (!rst_n)
        (r_q.st == DAU_ST_IDLE && wr_ctrl && r_q.en && reg_wdata[DAU_CRC_START_CMD]
         && !reg_wdata[DAU_CR_UPR] && !reg_wdata[DAU_UNIT_DISABLE_CMD] && !protected_mode
         && r_q.len[1:0] != 2'b00) |=> r_q.done && r_q.fail && r_q.st == DAU_ST_IDLE)
        else $error("misaligned range not failed");
    // A disabled unit is idle with nothing outstanding.
    AST_OFF_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
        (!r_q.en) |-> (r_q.st == DAU_ST_IDLE && !mem_req))
        else $error("disabled unit is busy");
    // Disable returns the data registers and flags to their reset values.
    AST_DIS_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_ctrl && reg_wdata[DAU_UNIT_DISABLE_CMD])
        |=> r_q.addr == '0 && r_q.len == '0 && r_q.data == '0 && !r_q.done && !r_q.fail)
        else $error("disable left state behind");
    // The enable command takes effect unless disable is written beside it.
    AST_EN_CMD: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_ctrl && reg_wdata[DAU_UNIT_ENABLE_CMD] && !reg_wdata[DAU_UNIT_DISABLE_CMD]) |=> r_q.en)
        else $error("enable command lost");
    // The interrupt line follows the masked sticky status.
    AST_IRQ_LVL: assert property (@(posedge clk) disable iff (!rst_n)
        irq == |(r_q.istat & r_q.imask))
        else $error("interrupt line wrong");
endmodule
`default_nettype wire

// >>> dv/dau_mem_model.sv
// Memory model that answers the word requests of the debug access unit.
`default_nettype none
module dau_mem_model
    import dau_pkg::*;
(
    input wire logic clk, // System clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic mem_req, // Word request from the unit.
    input wire logic [31:0] mem_addr, // Requested byte address.
    input wire logic mem_upage, // Request targets the user page.
    input wire logic [3:0] dly, // Answer delay in cycles.
    input wire logic err_en, // Allows a bus error answer.
    input wire logic [31:0] err_addr, // Address that is answered with a bus error.
    output logic mem_ack, // Answer strobe.
    output logic [31:0] mem_rdata, // Answer word.
    output logic mem_err // Bus error beside the answer.
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////////////
    logic ack_q = 1'b0; // Answer strobe register.
    logic err_q = 1'b0; // Error register.
    logic [31:0] dat_q = 32'h0000_0000; // Data register.
    logic [3:0] cnt_q = 4'h0; // Wait counter.
    // Contents scramble the address so that every word and both spaces differ.
    function automatic logic [31:0] word(input logic [31:0] a, input logic up);
        return {a[15:0], ~a[31:16]} ^ (up ? 32'h5A5A_0F0F : 32'h0000_0000);
    endfunction
    // Stale data toggles each cycle, so nobody can lean on the last word.
    always @(posedge clk) begin
        if (!rst_n || !mem_req || ack_q) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            cnt_q <= 4'h0;
            dat_q <= ~dat_q;
        end else if (cnt_q == dly) begin
            ack_q <= 1'b1;
            dat_q <= word(mem_addr, mem_upage);
            err_q <= err_en && (mem_addr == err_addr);
        end else begin
            cnt_q <= cnt_q + 4'h1;
            dat_q <= ~dat_q;
        end
    end
    assign mem_ack = ack_q;
    assign mem_rdata = dat_q;
    assign mem_err = err_q;
endmodule
`default_nettype wire

// >>> dv/dau_top_tb_top.sv
// Self-checking testbench of the debug access unit.
`default_nettype none
module dau_top_tb_top;
    import dau_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, protected_mode = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, mem_addr, mem_rdata;
    logic [31:0] err_addr = 32'h0000_0000, s, a;
    logic irq, mem_req, mem_upage, mem_ack, mem_err, err_en = 1'b0;
    logic [3:0] dly = 4'h2;
    int bad_count = 0, compares = 0;
    always #5 clk = ~clk;
    dau_top dau_top_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .protected_mode(protected_mode), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_upage(mem_upage), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_err(mem_err));
    dau_mem_model dau_mem_model_i (.clk(clk), .rst_n(rst_n), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_upage(mem_upage), .dly(dly), .err_en(err_en),
        .err_addr(err_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_err(mem_err));
    ////////////////////////////////////////////////////////////////////////////////
    // Prints the verdict and ends the run.
    task automatic print_verdict();
        if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Compares two words; a mismatch is printed and counted.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One-cycle write strobe.
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // One-cycle read strobe; data is taken in the following cycle only.
    task automatic rd(input logic [7:0] ad, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Polls the status until done, with a bounded count of polls.
    task automatic wait_done();
        int n;
        n = 0;
        s = 32'h0;
        while (s[DAU_DONE_FLAG] !== 1'b1) begin
            rd(DAU_OFF_STAT, s);
            n++;
            if (n > 500) begin
                bad_count++;
                print_verdict();
            end
        end
    endtask
    // Folds one word into the reflected CRC, least significant bit first.
    function automatic logic [31:0] fold(input logic [31:0] c, input logic [31:0] w);
        logic [31:0] r;
        r = c ^ w;
        for (int i = 0; i < 32; i++) r = r[0] ? ((r >> 1) ^ DAU_CRC_POLY) : (r >> 1);
        return r;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // Page read while protected, offset beyond the page, slow memory.
    task automatic t_page();
        protected_mode <= 1'b1;
        dly <= 4'h6;
        wr(DAU_OFF_CTRL, 32'h1 << DAU_UNIT_ENABLE_CMD);
        rd(DAU_OFF_STAT, s);
        chk({30'h0, s[9:8]}, 32'h0);
        wr(DAU_OFF_ADDR, 32'h0000_0FFC);
        wr(DAU_OFF_CTRL, 32'h1 << DAU_CR_UPR);
        rd(DAU_OFF_STAT, s);
        chk({30'h0, s[9:8]}, {30'h0, DAU_ST_UPR});
        a = mem_addr;
        chk({22'h0, mem_upage, mem_addr[8:0]}, {22'h0, 1'b1, 9'h1FC});
        wait_done();
        rd(DAU_OFF_DATA, s);
        chk(s, dau_mem_model_i.word(a, 1'b1));
        rd(DAU_OFF_ADDR, s);
        chk({23'h0, s[8:0]}, 32'h0);
    endtask
    // Two-word CRC with the all-ones seed.
    task automatic t_crc();
        protected_mode <= 1'b0;
        dly <= 4'h1;
        wr(DAU_OFF_ADDR, 32'h0000_0100);
        wr(DAU_OFF_LEN, 32'h0000_0008);
        wr(DAU_OFF_DATA, DAU_CRC_SEED);
        wr(DAU_OFF_CTRL, 32'h1 << DAU_CRC_START_CMD);
        wait_done();
        rd(DAU_OFF_DATA, s);
        a = fold(DAU_CRC_SEED, dau_mem_model_i.word(32'h100, 1'b0));
        chk(s, fold(a, dau_mem_model_i.word(32'h104, 1'b0)));
        rd(DAU_OFF_STAT, s);
        chk({29'h0, s[2:0]}, 32'h1);
    endtask
    // Bus error in mid-run, then interrupt mask and clear.
    task automatic t_berr();
        wr(DAU_OFF_IMASK, 32'h2);
        err_en <= 1'b1;
        err_addr <= 32'h0000_0204;
        wr(DAU_OFF_ADDR, 32'h0000_0200);
        wr(DAU_OFF_LEN, 32'h0000_0010);
        wr(DAU_OFF_CTRL, 32'h1 << DAU_CRC_START_CMD);
        wait_done();
        rd(DAU_OFF_STAT, s);
        chk({29'h0, s[2:0]}, 32'h3);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        wr(DAU_OFF_ISTAT, 32'h2);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        rd(DAU_OFF_ISTAT, s);
        chk(s, 32'h1);
        err_en <= 1'b0;
    endtask
    // Protected CRC ignores host values; disable aborts and resets the unit.
    task automatic t_abort();
        protected_mode <= 1'b1;
        dly <= 4'hF;
        wr(DAU_OFF_ADDR, 32'h0000_0300);
        wr(DAU_OFF_CTRL, 32'h1 << DAU_CRC_START_CMD);
        rd(DAU_OFF_STAT, s);
        chk({30'h0, s[9:8]}, {30'h0, DAU_ST_CRC});
        chk({mem_req, mem_upage, mem_addr[29:0]}, {2'b10, DAU_FLASH_BASE[29:0]});
        wr(DAU_OFF_CTRL, 32'h1 << DAU_UNIT_DISABLE_CMD);
        rd(DAU_OFF_STAT, s);
        chk({s[31:1], mem_req}, 32'h0);
        wr(DAU_OFF_CTRL, 32'h1 << DAU_UNIT_ENABLE_CMD);
        rd(DAU_OFF_STAT, s);
        chk(s, 32'h1 << DAU_SR_EN);
    endtask
    // Misaligned range fails at once; an empty range is done at once.
    task automatic t_fail();
        protected_mode <= 1'b0;
        wr(DAU_OFF_LEN, 32'h0000_0006);
        wr(DAU_OFF_CTRL, 32'h1 << DAU_CRC_START_CMD);
        rd(DAU_OFF_STAT, s);
        chk(s, 32'h0000_000D);
        wr(DAU_OFF_LEN, 32'h0000_0000);
        wr(DAU_OFF_CTRL, 32'h1 << DAU_CRC_START_CMD);
        rd(DAU_OFF_STAT, s);
        chk(s, 32'h0000_0009);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, then each scenario in turn.
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd(DAU_OFF_STAT, s);
        chk(s, 32'h0);
        rd(8'h1C, s);
        chk(s, 32'h0);
        t_page();
        t_crc();
        t_berr();
        t_abort();
        t_fail();
        print_verdict();
    end
endmodule
`default_nettype wire
